/* rtl/bfm_pkg.sv */
package bfm_pkg;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int FIFO_DEPTH = 8;
  localparam int SERIAL_BITS = 40;
  localparam int OFS_W = 20;
  localparam int SCNT_W = 6;
  localparam logic [SCNT_W-1:0] SERIAL_LAST = 6'h27;
  localparam logic [OFS_W-1:0] OFS_RST = 20'h00000;
  localparam logic [OFS_W-1:0] PRESET_8 = 20'h00008;
  localparam logic [OFS_W-1:0] PRESET_16 = 20'h00010;
  localparam logic [OFS_W-1:0] PRESET_64 = 20'h00040;
  localparam logic [1:0] SEL_PARALLEL = 2'h0;
  localparam logic [1:0] SEL_PRESET_8 = 2'h1;
  localparam logic [1:0] SEL_PRESET_16 = 2'h2;
  localparam logic [1:0] SEL_PRESET_64 = 2'h3;
  localparam logic [1:0] READY_WAIT_RST = 2'h0;
  localparam logic [1:0] READY_WAIT_MIN = 2'h2;
  typedef enum logic [1:0] {BFM_SERIAL, BFM_PARALLEL, BFM_PRESET} bfm_method_t;
endpackage

/* rtl/bfm_top.sv */
// How it works
// RULE1: Port B empty/ready shows A-to-B empty, or valid output word in FIRST_WORD_FALLTHROUGH_MODE.
// RULE2: Port A edges act only while port A gate is high; the code's serial shifts, ready wait and flag updates use ungated edges.
// RULE3: Port B edges act only while port B gate is high; the code's FIRST_WORD_FALLTHROUGH_MODE preload and flags use ungated edges.
// RULE4: Port A full/ready shows whether A-to-B FIFO can take a write.
// RULE5: Port B full/ready shows whether B-to-A FIFO can take a write.
// RULE6: Offset select pins and serial select decide offset programming at reset.
// RULE7: Offsets come from presets, a parallel port A write, or serial bits.
// RULE8: Serial mode shifts select-lo bit on port A edge while select-hi low.
// RULE9: A serial load is complete after exactly forty bits.
// RULE10: First serial bit is almost-full MSB, last is almost-empty LSB.
// RULE11: Port A read takes B-to-A mailbox when box select high, else FIFO.
// RULE12: Port A write goes to A-to-B mailbox when box select high, else FIFO.
// RULE13: Port B read takes A-to-B mailbox when box select high, else FIFO.
// RULE14: Port B write goes to B-to-A mailbox when box select high, else FIFO.
// RULE15: Writing A-to-B mailbox drops its flag; writes ignored while low.
// RULE16: Port B mailbox read or A-to-B reset raises A-to-B mail flag.
// RULE17: Writing B-to-A mailbox drops its flag; writes ignored while low.
// RULE18: Port A mailbox read or B-to-A reset raises B-to-A mail flag; the code has no B-to-A reset and raises it only on i_nrst low.
// RULE19: Master reset clears A-to-B pointers and zeroes port B output.
// RULE20: Master reset picks offset method, default offset and FIRST_WORD_FALLTHROUGH_MODE mode.
// RULE21: Host holds master reset low for four edges of each port clock.
// RULE22: Select levels are captured on the release edge of master reset.
// RULE23: Reset drops both flags; full/ready rises after two port clock edges.
// RULE24: Serial select low picks serial, high picks parallel or presets.
// RULE25: Partial reset clears pointers but keeps offsets and modes.
// RULE26: Flags are sampled only in their own port's update slot.
`timescale 1ns/1ns
`default_nettype none

module bfm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = count_reg != (AW+1)'(DEPTH);
  assign o_out_valid = count_reg != '0;
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || i_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge i_clk) begin
      if (push && wr_ptr_reg == AW'(i)) begin
        mem_reg[i] <= i_in_data;
      end
    end
  end
endmodule

module bfm_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_port_a_clock,
  input wire logic i_port_a_gate,
  input wire logic i_port_a_write,
  input wire logic i_port_a_box_select,
  input wire logic [bfm_pkg::DATA_W-1:0] i_a_data,
  output logic [bfm_pkg::DATA_W-1:0] o_a_data,
  output logic o_a_data_oe_n,
  input wire logic i_port_b_clock,
  input wire logic i_port_b_gate,
  input wire logic i_port_b_write,
  input wire logic i_port_b_box_select,
  input wire logic [bfm_pkg::DATA_W-1:0] i_b_data,
  output logic [bfm_pkg::DATA_W-1:0] o_b_data,
  output logic o_b_data_oe_n,
  input wire logic i_fifo_a_to_b_master_reset_n,
  input wire logic i_fifo_a_to_b_partial_reset_n,
  input wire logic i_offset_select_hi,
  input wire logic i_offset_select_lo,
  input wire logic i_serial_program_select,
  input wire logic i_first_word_fallthrough_mode,
  output logic o_port_a_full_or_ready,
  output logic o_port_b_empty_or_ready,
  output logic o_port_b_full_or_ready,
  output logic o_a_to_b_mail_flag,
  output logic o_b_to_a_mail_flag,
  output logic [bfm_pkg::OFS_W-1:0] o_almost_full_offset,
  output logic [bfm_pkg::OFS_W-1:0] o_almost_empty_offset,
  output logic o_offsets_loaded
);
  import bfm_pkg::*;

  logic a_clk_q, b_clk_q, mrs_q, a_upd, b_upd;
  logic first_word_fallthrough_mode_reg, b_valid_reg;
  bfm_method_t method_reg;
  logic [1:0] wait_a_reg;
  logic [SERIAL_BITS-1:0] sr_reg;
  logic [SERIAL_BITS-1:0] sr_next;
  logic [SCNT_W-1:0] scnt_reg;
  logic [DATA_W-1:0] a_to_b_mailbox_reg, b_to_a_mailbox_reg;
  logic f1_in_ready, f1_valid, f2_in_ready, f2_valid;
  logic [DATA_W-1:0] f1_data, f2_data;
  logic a_edge, b_edge, mrs_rise, f1_clr, shift_en;
  logic a_wr, a_rd, b_wr, b_rd;
  logic a_mail_wr, a_fifo_wr, a_mail_rd, a_par_wr, pop2;
  logic b_mail_wr, b_fifo_wr, b_mail_rd, b_fifo_rd, pop1;

  assign a_edge = i_port_a_clock && !a_clk_q;
  assign b_edge = i_port_b_clock && !b_clk_q;
  assign mrs_rise = i_fifo_a_to_b_master_reset_n && !mrs_q;
  assign f1_clr = !i_nrst || !i_fifo_a_to_b_master_reset_n ||
                  !i_fifo_a_to_b_partial_reset_n; // RULE19 RULE25
  assign a_wr = a_edge && i_port_a_gate && i_port_a_write; // RULE2
  assign a_rd = a_edge && i_port_a_gate && !i_port_a_write; // RULE2
  assign b_wr = b_edge && i_port_b_gate && i_port_b_write; // RULE3
  assign b_rd = b_edge && i_port_b_gate && !i_port_b_write; // RULE3
  assign a_mail_wr = a_wr && i_port_a_box_select && o_a_to_b_mail_flag; // RULE12 RULE15
  assign a_fifo_wr = a_wr && !i_port_a_box_select &&
                     o_port_a_full_or_ready; // RULE12
  assign a_par_wr = a_wr && !i_port_a_box_select &&
                    method_reg == BFM_PARALLEL && !o_offsets_loaded; // RULE7
  assign a_mail_rd = a_rd && i_port_a_box_select; // RULE11
  assign pop2 = a_rd && !i_port_a_box_select && f2_valid; // RULE11
  assign b_mail_wr = b_wr && i_port_b_box_select && o_b_to_a_mail_flag; // RULE14 RULE17
  assign b_fifo_wr = b_wr && !i_port_b_box_select &&
                     o_port_b_full_or_ready; // RULE14
  assign b_mail_rd = b_rd && i_port_b_box_select; // RULE13
  assign b_fifo_rd = b_rd && !i_port_b_box_select; // RULE13
  // FIRST_WORD_FALLTHROUGH_MODE pre-loads the output register on a port B edge when it holds no word
  assign pop1 = b_edge && f1_valid && !b_mail_rd &&
                (first_word_fallthrough_mode_reg ? (!b_valid_reg || b_fifo_rd) : b_fifo_rd); // RULE1
  assign sr_next = {sr_reg[SERIAL_BITS-2:0], i_offset_select_lo}; // RULE10
  assign shift_en = method_reg == BFM_SERIAL && !o_offsets_loaded &&
                    a_edge && !i_offset_select_hi; // RULE8

  bfm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo_a_to_b (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_clear(f1_clr),
    .i_in_valid(a_fifo_wr), .o_in_ready(f1_in_ready),
    .i_in_data(i_a_data), .o_out_valid(f1_valid),
    .i_out_ready(pop1), .o_out_data(f1_data)
  );

  bfm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo_b_to_a (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_clear(1'b0),
    .i_in_valid(b_fifo_wr), .o_in_ready(f2_in_ready),
    .i_in_data(i_b_data), .o_out_valid(f2_valid),
    .i_out_ready(pop2), .o_out_data(f2_data)
  );

  // Port clock edge detect; flags update one cycle after the edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
      // Idle level of the reset pin, so no false release edge
      mrs_q <= 1'b1;
      a_upd <= 1'b0;
      b_upd <= 1'b0;
    end else begin
      a_clk_q <= i_port_a_clock;
      b_clk_q <= i_port_b_clock;
      mrs_q <= i_fifo_a_to_b_master_reset_n;
      a_upd <= a_edge;
      b_upd <= b_edge;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      method_reg <= BFM_PRESET;
      first_word_fallthrough_mode_reg <= 1'b0;
    end else if (mrs_rise) begin
      first_word_fallthrough_mode_reg <= i_first_word_fallthrough_mode; // RULE20 RULE22
      if (!i_serial_program_select) begin
        method_reg <= BFM_SERIAL; // RULE24
      end else if ({i_offset_select_hi, i_offset_select_lo} ==
                   SEL_PARALLEL) begin
        method_reg <= BFM_PARALLEL; // RULE6
      end else begin
        method_reg <= BFM_PRESET; // RULE6
      end
    end
  end

  // Offsets survive partial reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_almost_full_offset <= OFS_RST;
      o_almost_empty_offset <= OFS_RST;
      o_offsets_loaded <= 1'b0;
      sr_reg <= '0;
      scnt_reg <= '0;
    end else if (!i_fifo_a_to_b_master_reset_n) begin
      o_offsets_loaded <= 1'b0; // RULE25
      scnt_reg <= '0;
    end else if (mrs_rise) begin
      o_offsets_loaded <= i_serial_program_select &&
          {i_offset_select_hi, i_offset_select_lo} != SEL_PARALLEL; // RULE6
      case ({i_offset_select_hi, i_offset_select_lo})
        SEL_PRESET_8: begin
          o_almost_full_offset <= PRESET_8; // RULE7 RULE20
          o_almost_empty_offset <= PRESET_8;
        end
        SEL_PRESET_16: begin
          o_almost_full_offset <= PRESET_16; // RULE7
          o_almost_empty_offset <= PRESET_16;
        end
        SEL_PRESET_64: begin
          o_almost_full_offset <= PRESET_64; // RULE7
          o_almost_empty_offset <= PRESET_64;
        end
        default: begin
          o_almost_full_offset <= o_almost_full_offset;
        end
      endcase
    end else if (shift_en) begin
      sr_reg <= sr_next; // RULE8
      scnt_reg <= scnt_reg + 6'h01;
      if (scnt_reg == SERIAL_LAST) begin
        o_offsets_loaded <= 1'b1; // RULE9
        o_almost_full_offset <= sr_next[SERIAL_BITS-1:OFS_W]; // RULE10
        o_almost_empty_offset <= sr_next[OFS_W-1:0];
      end
    end else if (a_par_wr) begin
      o_almost_full_offset <= OFS_W'(i_a_data[DATA_W-1:HALF_W]); // RULE7
      o_almost_empty_offset <= OFS_W'(i_a_data[HALF_W-1:0]);
      o_offsets_loaded <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (f1_clr) begin
      wait_a_reg <= READY_WAIT_RST;
      o_port_a_full_or_ready <= 1'b0; // RULE23
      o_port_b_empty_or_ready <= 1'b0; // RULE23
    end else begin
      // Second port A edge after reset opens the ready flag
      if (a_edge && wait_a_reg != READY_WAIT_MIN) begin
        wait_a_reg <= wait_a_reg + 2'h1;
      end
      if (a_upd) begin
        o_port_a_full_or_ready <= f1_in_ready && // RULE4 RULE26
            o_offsets_loaded && wait_a_reg == READY_WAIT_MIN; // RULE23
      end
      if (b_upd) begin
        o_port_b_empty_or_ready <= first_word_fallthrough_mode_reg ? b_valid_reg : f1_valid; // RULE1 RULE26
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_port_b_full_or_ready <= 1'b0;
    end else if (b_upd) begin
      o_port_b_full_or_ready <= f2_in_ready; // RULE5 RULE26
    end
  end

  always_ff @(posedge i_clk) begin
    if (f1_clr) begin
      o_b_data <= '0; // RULE19
      b_valid_reg <= 1'b0;
    end else if (b_edge) begin
      if (b_mail_rd) begin
        o_b_data <= a_to_b_mailbox_reg; // RULE13
      end else if (pop1) begin
        o_b_data <= f1_data; // RULE13
      end
      if (pop1) begin
        b_valid_reg <= 1'b1;
      end else if (b_fifo_rd) begin
        b_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_a_data <= '0;
      o_a_data_oe_n <= 1'b1;
      o_b_data_oe_n <= 1'b1;
    end else begin
      o_a_data_oe_n <= !(i_port_a_gate && !i_port_a_write);
      o_b_data_oe_n <= !(i_port_b_gate && !i_port_b_write);
      if (a_mail_rd) begin
        o_a_data <= b_to_a_mailbox_reg; // RULE11
      end else if (pop2) begin
        o_a_data <= f2_data; // RULE11
      end
    end
  end

  // Mailboxes; a write in the same cycle as the freeing read is ignored, the read wins
  always_ff @(posedge i_clk) begin
    if (f1_clr) begin
      o_a_to_b_mail_flag <= 1'b1; // RULE16
    end else if (a_mail_wr) begin
      o_a_to_b_mail_flag <= 1'b0; // RULE15
    end else if (b_mail_rd) begin
      o_a_to_b_mail_flag <= 1'b1; // RULE16
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_b_to_a_mail_flag <= 1'b1; // RULE18
    end else if (b_mail_wr) begin
      o_b_to_a_mail_flag <= 1'b0; // RULE17
    end else if (a_mail_rd) begin
      o_b_to_a_mail_flag <= 1'b1; // RULE18
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      a_to_b_mailbox_reg <= '0;
      b_to_a_mailbox_reg <= '0;
    end else begin
      if (a_mail_wr) begin
        a_to_b_mailbox_reg <= i_a_data; // RULE12
      end
      if (b_mail_wr) begin
        b_to_a_mailbox_reg <= i_b_data; // RULE14
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_mrs_release;
    !i_fifo_a_to_b_master_reset_n ##1 i_fifo_a_to_b_master_reset_n;
  endsequence
  sequence s_last_shift;
    shift_en && scnt_reg == SERIAL_LAST &&
      i_fifo_a_to_b_master_reset_n && !mrs_rise;
  endsequence

  property p_empty_std;
    (b_upd && !first_word_fallthrough_mode_reg && !f1_clr) |=>
      o_port_b_empty_or_ready == $past(f1_valid);
  endproperty
  a_empty_std: assert property (p_empty_std) // RULE1
    else $error("port B empty flag wrong in standard mode");
  property p_full_rise;
    $rose(o_port_a_full_or_ready) |->
      $past(o_offsets_loaded) && $past(wait_a_reg) == READY_WAIT_MIN;
  endproperty
  a_full_rise: assert property (p_full_rise) // RULE4
    else $error("port A ready rose too early");
  property p_capture;
    s_mrs_release |=>
      first_word_fallthrough_mode_reg == $past(i_first_word_fallthrough_mode);
  endproperty
  a_capture: assert property (p_capture) // RULE22
    else $error("mode not captured at reset release");
  property p_serial_order;
    s_last_shift |=> o_offsets_loaded &&
      o_almost_full_offset[OFS_W-1] == $past(sr_reg[SERIAL_BITS-2]) &&
      o_almost_empty_offset[0] == $past(i_offset_select_lo);
  endproperty
  a_serial_order: assert property (p_serial_order) // RULE10
    else $error("serial offset bit order wrong");
  property p_a_to_b_mailbox_low;
    a_mail_wr && !f1_clr |=>
      !o_a_to_b_mail_flag && a_to_b_mailbox_reg == $past(i_a_data);
  endproperty
  a_a_to_b_mailbox_low: assert property (p_a_to_b_mailbox_low) // RULE15
    else $error("mailbox A-to-B write not taken");
  property p_a_to_b_mailbox_keep;
    (!o_a_to_b_mail_flag && !b_mail_rd && !f1_clr) |=>
      $stable(a_to_b_mailbox_reg) && !o_a_to_b_mail_flag;
  endproperty
  a_a_to_b_mailbox_keep: assert property (p_a_to_b_mailbox_keep) // RULE15
    else $error("mailbox A-to-B changed while full");
  property p_a_to_b_mailbox_high;
    (b_mail_rd && !a_mail_wr) |=> o_a_to_b_mail_flag;
  endproperty
  a_a_to_b_mailbox_high: assert property (p_a_to_b_mailbox_high) // RULE16
    else $error("mailbox A-to-B flag not freed");
  property p_b_to_a_mailbox_keep;
    (!o_b_to_a_mail_flag && !a_mail_rd) |=>
      $stable(b_to_a_mailbox_reg) && !o_b_to_a_mail_flag;
  endproperty
  a_b_to_a_mailbox_keep: assert property (p_b_to_a_mailbox_keep) // RULE17
    else $error("mailbox B-to-A changed while full");
  property p_b_to_a_mailbox_high;
    (a_mail_rd && !b_mail_wr) |=> o_b_to_a_mail_flag &&
      o_a_data == $past(b_to_a_mailbox_reg);
  endproperty
  a_b_to_a_mailbox_high: assert property (p_b_to_a_mailbox_high) // RULE18
    else $error("mailbox B-to-A read wrong");
  property p_b_to_a_mailbox_low;
    b_mail_wr |=> !o_b_to_a_mail_flag && b_to_a_mailbox_reg == $past(i_b_data);
  endproperty
  a_b_to_a_mailbox_low: assert property (p_b_to_a_mailbox_low) // RULE17
    else $error("mailbox B-to-A write not taken");
  property p_reset_clear;
    !i_fifo_a_to_b_master_reset_n |=> !f1_valid && o_b_data == '0 &&
      !o_port_a_full_or_ready && !o_port_b_empty_or_ready;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RULE19
    else $error("master reset did not clear A-to-B state");
endmodule

`default_nettype wire

/* rtl/bfm_unused_placeholder_removed.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* sim/bfm_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Port host: one port clock edge per call, selects held across the edge
module bfm_host (
  input wire logic i_clk,
  output logic o_clock,
  output logic o_gate,
  output logic o_write,
  output logic o_box,
  output logic [bfm_pkg::DATA_W-1:0] o_data,
  input wire logic [bfm_pkg::DATA_W-1:0] i_data,
  input wire logic i_oe_n
);
  import bfm_pkg::*;
  initial begin
    o_clock = 1'b0;
    o_gate = 1'b0;
    o_write = 1'b0;
    o_box = 1'b0;
    o_data = 36'h0;
  end
  task automatic op(input logic en, input logic wr, input logic box,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
      output logic oe_n);
    @(negedge i_clk);
    o_gate = en;
    o_write = wr;
    o_box = box;
    if (wr) o_data = d;
    @(negedge i_clk);
    o_clock = 1'b1;
    @(negedge i_clk);
    @(negedge i_clk);
    q = i_data;
    oe_n = i_oe_n;
    o_clock = 1'b0;
    o_gate = 1'b0;
    // Released bus shows the inverse of the word it held
    o_data = ~o_data;
    @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bfm_pkg::*;
  localparam logic [DATA_W-1:0] PAR_WORD = 36'h9_8765_4321;
  localparam logic [39:0] SER_PAT = 40'hA5_3C_96_0F_E1;
  localparam logic [OFS_W-1:0] PRE [3] = '{PRESET_8, PRESET_16, PRESET_64};
  logic clk, nrst, mrst_n, prst_n, hi, lo, serial_program_select, first_word_fallthrough_mode;
  logic ack, ag, aw, abox, bck, bg, bw, bbox, aoe, boe, oea, oeb;
  logic a_rdy, b_ept, b_rdy, ab_mf, ba_mf, ldd;
  logic [DATA_W-1:0] ai, ao, bi, bo, qa, qb;
  logic [OFS_W-1:0] afo, aeo;
  int err_count;
  int checked;

  bfm_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_port_a_clock(ack),
    .i_port_a_gate(ag), .i_port_a_write(aw), .i_port_a_box_select(abox),
    .i_a_data(ai), .o_a_data(ao), .o_a_data_oe_n(aoe),
    .i_port_b_clock(bck), .i_port_b_gate(bg), .i_port_b_write(bw),
    .i_port_b_box_select(bbox), .i_b_data(bi), .o_b_data(bo),
    .o_b_data_oe_n(boe), .i_fifo_a_to_b_master_reset_n(mrst_n),
    .i_fifo_a_to_b_partial_reset_n(prst_n), .i_offset_select_hi(hi),
    .i_offset_select_lo(lo), .i_serial_program_select(serial_program_select),
    .i_first_word_fallthrough_mode(first_word_fallthrough_mode), .o_port_a_full_or_ready(a_rdy),
    .o_port_b_empty_or_ready(b_ept), .o_port_b_full_or_ready(b_rdy),
    .o_a_to_b_mail_flag(ab_mf), .o_b_to_a_mail_flag(ba_mf),
    .o_almost_full_offset(afo), .o_almost_empty_offset(aeo),
    .o_offsets_loaded(ldd));
  bfm_host host_a (.i_clk(clk), .o_clock(ack), .o_gate(ag), .o_write(aw),
    .o_box(abox), .o_data(ai), .i_data(ao), .i_oe_n(aoe));
  bfm_host host_b (.i_clk(clk), .o_clock(bck), .o_gate(bg), .o_write(bw),
    .o_box(bbox), .o_data(bi), .i_data(bo), .i_oe_n(boe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic xa(input logic en, input logic wr, input logic box,
      input logic [DATA_W-1:0] d);
    host_a.op(en, wr, box, d, qa, oea);
  endtask
  task automatic xb(input logic en, input logic wr, input logic box,
      input logic [DATA_W-1:0] d);
    host_b.op(en, wr, box, d, qb, oeb);
  endtask
  task automatic tick_a;
    xa(1'b0, 1'b0, 1'b0, '0);
  endtask
  task automatic tick_b;
    xb(1'b0, 1'b0, 1'b0, '0);
  endtask

  // Master or partial reset with four edges on each port
  task automatic pulse(input logic part, input logic s, input logic h,
      input logic l, input logic f);
    serial_program_select = s;
    hi = h;
    lo = l;
    first_word_fallthrough_mode = f;
    if (part) prst_n = 1'b0;
    else mrst_n = 1'b0;
    fork
      repeat (4) tick_a();
      repeat (4) tick_b();
    join
    chk_bit(ab_mf, 1'b1);
    chk_bit(b_ept, 1'b0);
    chk_bit(a_rdy, 1'b0);
    chk_word(bo, '0);
    mrst_n = 1'b1;
    prst_n = 1'b1;
    @(negedge clk);
    // Offset selects move after release so only a latched value survives
    hi = 1'b1;
    lo = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_presets;
    logic [1:0] sel;
    for (int k = 1; k < 4; k++) begin
      sel = 2'(k);
      pulse(1'b0, 1'b1, sel[1], sel[0], 1'b0);
      chk_bit(ldd, 1'b1);
      chk_word(36'(afo), 36'(PRE[k-1]));
      chk_word(36'(aeo), 36'(PRE[k-1]));
      tick_a();
      chk_bit(a_rdy, 1'b0);
      tick_a();
      chk_bit(a_rdy, 1'b1);
    end
  endtask

  task automatic t_serial;
    pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int i = 39; i >= 0; i--) begin
      if (i == 0) chk_bit(ldd, 1'b0);
      hi = 1'b0;
      lo = SER_PAT[i];
      tick_a();
    end
    hi = 1'b1;
    chk_bit(ldd, 1'b1);
    chk_word(36'(afo), 36'(SER_PAT[39:20]));
    chk_word(36'(aeo), 36'(SER_PAT[19:0]));
  endtask

  task automatic t_fifo_ab;
    pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    xa(1'b1, 1'b1, 1'b0, PAR_WORD);
    chk_word(36'(afo), 36'(PAR_WORD[35:18]));
    chk_word(36'(aeo), 36'(PAR_WORD[17:0]));
    tick_a();
    for (int i = 0; i < FIFO_DEPTH; i++) xa(1'b1, 1'b1, 1'b0, 36'(i + 'h100));
    chk_bit(a_rdy, 1'b0);
    xa(1'b1, 1'b1, 1'b0, 36'hF_FFFF_FFFF);
    tick_b();
    chk_bit(b_ept, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      xb(1'b1, 1'b0, 1'b0, '0);
      chk_word(qb, 36'(i + 'h100));
    end
    chk_bit(oeb, 1'b0);
    tick_b();
    chk_bit(b_ept, 1'b0);
    tick_a();
    chk_bit(a_rdy, 1'b1);
  endtask

  task automatic t_mail;
    xa(1'b0, 1'b1, 1'b1, 36'h1_1111_1111);
    chk_bit(ab_mf, 1'b1);
    xa(1'b1, 1'b1, 1'b1, 36'h2_2222_2222);
    chk_bit(ab_mf, 1'b0);
    xa(1'b1, 1'b1, 1'b1, 36'h3_3333_3333);
    xb(1'b1, 1'b0, 1'b1, '0);
    chk_word(qb, 36'h2_2222_2222);
    chk_bit(ab_mf, 1'b1);
    xb(1'b0, 1'b1, 1'b1, 36'h4_4444_4444);
    chk_bit(ba_mf, 1'b1);
    xb(1'b1, 1'b1, 1'b1, 36'h5_5555_5555);
    chk_bit(ba_mf, 1'b0);
    xb(1'b1, 1'b1, 1'b1, 36'h6_6666_6666);
    xa(1'b1, 1'b0, 1'b1, '0);
    chk_word(qa, 36'h5_5555_5555);
    chk_bit(ba_mf, 1'b1);
  endtask

  task automatic t_fifo_ba;
    chk_bit(b_rdy, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) xb(1'b1, 1'b1, 1'b0, 36'(i + 'h200));
    chk_bit(b_rdy, 1'b0);
    xb(1'b1, 1'b1, 1'b0, 36'hF_FFFF_FFFF);
    tick_a();
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      xa(1'b1, 1'b0, 1'b0, '0);
      chk_word(qa, 36'(i + 'h200));
    end
    xa(1'b1, 1'b0, 1'b0, '0);
    chk_word(qa, 36'h0_0000_0207);
    chk_bit(oea, 1'b0);
    tick_b();
    chk_bit(b_rdy, 1'b1);
  endtask

  task automatic t_partial;
    xa(1'b1, 1'b1, 1'b0, 36'h7_7777_7777);
    xa(1'b1, 1'b1, 1'b1, 36'h8_8888_8888);
    tick_b();
    xb(1'b1, 1'b0, 1'b0, '0);
    chk_word(qb, 36'h7_7777_7777);
    pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    chk_bit(ldd, 1'b1);
    chk_word(36'(afo), 36'(PAR_WORD[35:18]));
    chk_word(36'(aeo), 36'(PAR_WORD[17:0]));
  endtask

  task automatic t_first_word_fallthrough_mode;
    pulse(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (2) tick_a();
    xa(1'b1, 1'b1, 1'b0, 36'hA_BCDE_F012);
    repeat (2) tick_b();
    chk_bit(b_ept, 1'b1);
    chk_word(bo, 36'hA_BCDE_F012);
    xb(1'b1, 1'b0, 1'b0, '0);
    tick_b();
    chk_bit(b_ept, 1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    checked = 0;
    nrst = 1'b0;
    mrst_n = 1'b1;
    prst_n = 1'b1;
    hi = 1'b1;
    lo = 1'b0;
    serial_program_select = 1'b1;
    first_word_fallthrough_mode = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(ab_mf, 1'b1);
    chk_bit(ba_mf, 1'b1);
    chk_bit(a_rdy, 1'b0);
    t_presets();
    t_serial();
    t_fifo_ab();
    t_mail();
    t_fifo_ba();
    t_partial();
    t_first_word_fallthrough_mode();
    finish_test();
  end
endmodule
`default_nettype wire
